// ### timer16_defines.svh
// constants for the gated prescaled 16-bit timer
`ifndef TIMER16_DEFINES_SVH
`define TIMER16_DEFINES_SVH
`define OFS_COUNT 12'h000
`define OFS_PERIOD 12'h004
`define OFS_CONTROL 12'h008
`define OFS_IRQ 12'h00C
`define BIT_RUN 15
`define BIT_GATE 6
`define BIT_PS_HI 5
`define BIT_PS_LO 4
`define BIT_CLK_SRC 1
`define CTRL_MASK 16'h8072
`define IRQ_FLAG_BIT 0
`define IRQ_EN_BIT 1
`define IRQ_PRI_HI 4
`define IRQ_PRI_LO 2
`define PS_DIV1 2'h0
`define PS_DIV8 2'h1
`define PS_DIV64 2'h2
`define PS_DIV256 2'h3
`define PS_MAX8 8'h07
`define PS_MAX64 8'h3F
`define PS_MAX256 8'hFF
`define ADDR_LSB 2
`endif

// ### timer16_pkg.sv
// types for the gated prescaled 16-bit timer
package timer16_pkg;
   typedef logic [15:0] word_t;
endpackage : timer16_pkg

// ### gated_prescaled_timer16.sv
// gated prescaled 16-bit timer with an apb register slave
// Overview of operation
// - gated mode counts ticks while gate high
// - gate falling edge sets flag, two cycles after the synced fall
// - gate fall holds count, resumes later
// - gated mode: period match never sets flag
// - prescale divides by 1, 8, 64, 256
// - prescaler cleared on count write, stop, reset
// - control write leaves count unchanged
// - otherwise flag set on period match
// - flag sticky until software clears it
// - request needs flag, enable, nonzero priority
// - zero period gives no match interrupts
// - byte or word writes accepted
// - external clock prescaled before synchronising
// - prescale codes 00,01,10,11 map to dividers
// - source bit one selects external pin
// - run bit starts and stops counting
// - count write suppresses that cycle's increment
//
// Our own choices: the APB slave port and the register offsets.
`include "timer16_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module gated_prescaled_timer16
(
   input wire logic clk_in, // 200 MHz clock
   input wire logic rst_n_in, // async active-low reset
   input wire logic psel_in, // apb select
   input wire logic penable_in, // apb enable
   input wire logic pwrite_in, // apb write
   input wire logic [11:0] paddr_in, // apb byte address
   input wire logic [31:0] pwdata_in, // apb write data
   input wire logic [3:0] pstrb_in, // apb byte strobes
   output logic [31:0] prdata_out, // apb read data
   output logic pready_out, // apb ready
   output logic pslverr_out, // apb error
   input wire logic ext_clock_gate_pin_in, // ext clock or gate pin
   output var timer16_pkg::word_t count_out, // current count
   output logic irq_out // interrupt request
);
   import timer16_pkg::*;

   // reset release through two flops
   logic rst_meta_r, rst_n_r;
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in) {rst_n_r, rst_meta_r} <= 2'h0;
      else {rst_n_r, rst_meta_r} <= {rst_meta_r, 1'h1};
   end

   word_t count_register_r, period_register_r, control_register_r;
   logic irq_flag_r, irq_enable_r;
   logic [2:0] irq_priority_r;
   logic [7:0] ps_cnt_r;
   logic pin_meta_r, pin_sync_r, pin_prev_r;
   logic ext_div_r, ext_meta_r, ext_sync_r, ext_prev_r;
   logic gate_fall_r;

   // apb decode, zero-wait answer
   wire acc = psel_in && penable_in;
   wire wr = acc && pwrite_in;
   wire hit_cnt = (paddr_in == `OFS_COUNT);
   wire hit_per = (paddr_in == `OFS_PERIOD);
   wire hit_ctl = (paddr_in == `OFS_CONTROL);
   wire hit_irq = (paddr_in == `OFS_IRQ);
   wire mapped = hit_cnt | hit_per | hit_ctl | hit_irq;
   wire [1:0] lo_ok = {pstrb_in[1], pstrb_in[0]};
   assign pready_out = 1'h1;
   assign pslverr_out = acc && (!mapped || (pstrb_in[3:2] != 2'h0));
   wire wr_ok = wr && !pslverr_out;
   wire wr_cnt = wr_ok && hit_cnt && (lo_ok != 2'h0);
   wire wr_per = wr_ok && hit_per;
   wire wr_ctl = wr_ok && hit_ctl;
   wire wr_irq = wr_ok && hit_irq && pstrb_in[0];

   // byte-lane merge for 16-bit registers
   function automatic word_t merge(input word_t old, input logic [31:0] d,
                                   input logic [3:0] s);
      merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction : merge

   // control fields
   wire run_bit = control_register_r[`BIT_RUN];
   wire clock_source_select = control_register_r[`BIT_CLK_SRC];
   wire gate_accumulate_enable = control_register_r[`BIT_GATE]
      && !clock_source_select;
   wire [1:0] prescale_select =
      control_register_r[`BIT_PS_HI:`BIT_PS_LO];

   // prescale terminal count per code
   logic [7:0] ps_max;
   always_comb
   begin
      unique case (prescale_select)
         `PS_DIV1: ps_max = 8'h00;
         `PS_DIV8: ps_max = `PS_MAX8;
         `PS_DIV64: ps_max = `PS_MAX64;
         `PS_DIV256: ps_max = `PS_MAX256;
      endcase
   end

   // prescaler input: every clock, whichever source is selected
   wire ext_rise = ext_sync_r && !ext_prev_r;
   wire int_tick_src = 1'h1;
   wire ps_in = clock_source_select ? 1'h1 : int_tick_src;
   wire ps_clr = wr_cnt || !run_bit;
   wire ps_wrap = (ps_cnt_r == ps_max);
   wire int_tick = ps_in && ps_wrap && !clock_source_select;

   // prescaler counter for the internal clock
   always_ff @(posedge clk_in or negedge rst_n_r)
   begin
      if (!rst_n_r) ps_cnt_r <= 8'h00;
      else if (ps_clr || ps_wrap) ps_cnt_r <= 8'h00;
      else ps_cnt_r <= ps_cnt_r + 8'h01;
   end

   // external pin divided before synchronising
   logic [7:0] ext_cnt_r;
   logic pin_raw_prev_r;
   wire raw_rise = ext_clock_gate_pin_in && !pin_raw_prev_r;
   always_ff @(posedge clk_in or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         ext_cnt_r <= 8'h00;
         ext_div_r <= 1'h0;
         pin_raw_prev_r <= 1'h0;
      end
      else
      begin
         pin_raw_prev_r <= ext_clock_gate_pin_in;
         if (ps_clr) ext_cnt_r <= 8'h00;
         else if (raw_rise)
         begin
            ext_cnt_r <= (ext_cnt_r == ps_max) ? 8'h00 : ext_cnt_r + 8'h01;
            if (ext_cnt_r == ps_max) ext_div_r <= !ext_div_r;
         end
      end
   end

   // synchronisers for divided clock and gate
   always_ff @(posedge clk_in or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         {ext_prev_r, ext_sync_r, ext_meta_r} <= 3'h0;
         {pin_prev_r, pin_sync_r, pin_meta_r} <= 3'h0;
      end
      else
      begin
         {ext_prev_r, ext_sync_r, ext_meta_r} <=
            {ext_sync_r, ext_meta_r, ext_div_r};
         {pin_prev_r, pin_sync_r, pin_meta_r} <=
            {pin_sync_r, pin_meta_r, ext_clock_gate_pin_in};
      end
   end

   // toggled divider: each toggle is one divided period
   wire ext_tick = clock_source_select && (ext_sync_r != ext_prev_r);
   wire gate_fall = pin_prev_r && !pin_sync_r;
   wire gate_open = !gate_accumulate_enable || pin_sync_r;
   wire tick = run_bit && (int_tick || ext_tick) && gate_open;
   wire match = (count_register_r == period_register_r);
   wire match_tick = tick && match;
   wire per_zero = (period_register_r == 16'h0000);

   // count: write wins over increment, match restarts at zero
   word_t count_nxt;
   always_comb
   begin
      if (wr_cnt) count_nxt = merge(count_register_r, pwdata_in,
                                    pstrb_in);
      else if (match_tick) count_nxt = 16'h0000;
      else if (tick) count_nxt = count_register_r + 16'h0001;
      else count_nxt = count_register_r;
   end

   // flag events; set beats clear
   wire set_match = match_tick && !gate_accumulate_enable && !per_zero;
   wire set_gate = gate_accumulate_enable && run_bit && gate_fall_r;
   wire flag_set = set_match || set_gate;
   wire flag_clr = wr_irq && !pwdata_in[`IRQ_FLAG_BIT];

   // register file
   always_ff @(posedge clk_in or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         count_register_r <= 16'h0000;
         period_register_r <= 16'hFFFF;
         control_register_r <= 16'h0000;
         irq_flag_r <= 1'h0;
         irq_enable_r <= 1'h0;
         irq_priority_r <= 3'h0;
         gate_fall_r <= 1'h0;
      end
      else
      begin
         count_register_r <= count_nxt;
         gate_fall_r <= gate_fall;
         if (wr_per) period_register_r <= merge(period_register_r,
                                                pwdata_in, pstrb_in);
         if (wr_ctl) control_register_r <= merge(control_register_r,
            pwdata_in, pstrb_in) & `CTRL_MASK;
         if (flag_set) irq_flag_r <= 1'h1;
         else if (flag_clr) irq_flag_r <= 1'h0;
         if (wr_irq)
         begin
            irq_enable_r <= pwdata_in[`IRQ_EN_BIT];
            irq_priority_r <= pwdata_in[`IRQ_PRI_HI:`IRQ_PRI_LO];
         end
      end
   end

   // read data, word reads only
   wire byte_rd = acc && !pwrite_in && (pstrb_in != 4'h0) &&
      (pstrb_in[1:0] != 2'h3);
   word_t ctl_view, irq_view, rd_word;
   assign ctl_view = {control_register_r[15:7],
      gate_accumulate_enable, control_register_r[5:0]};
   assign irq_view = {11'h000, irq_priority_r, irq_enable_r, irq_flag_r};
   assign rd_word = hit_cnt ? count_register_r :
      hit_per ? period_register_r :
      hit_ctl ? ctl_view : hit_irq ? irq_view : 16'h0000;
   assign prdata_out = byte_rd ? 32'h0 : {16'h0000, rd_word};
   assign count_out = count_register_r;
   assign irq_out = irq_flag_r && irq_enable_r &&
      (irq_priority_r != 3'h0);

   // checks
   gate_flag_a: assert property (@(posedge clk_in) disable iff (!rst_n_r)
      (gate_fall && gate_accumulate_enable && run_bit) |-> ##2 irq_flag_r)
      else $error("gate fall did not set flag");
   no_gate_cnt_a: assert property (@(posedge clk_in) disable iff (!rst_n_r)
      (gate_accumulate_enable && !pin_sync_r && !wr_cnt) |=>
      $stable(count_register_r))
      else $error("count moved with gate low");
   sticky_flag_a: assert property (@(posedge clk_in) disable iff (!rst_n_r)
      (irq_flag_r && !flag_clr) |=> irq_flag_r)
      else $error("flag cleared by itself");
   irq_gate_a: assert property (@(posedge clk_in) disable iff (!rst_n_r)
      irq_out |-> (irq_priority_r != 3'h0) && irq_enable_r)
      else $error("irq without enable");
   ctl_keep_a: assert property (@(posedge clk_in) disable iff (!rst_n_r)
      (wr_ctl && !tick) |=> $stable(count_register_r))
      else $error("control write changed count");
   gated_match_a: assert property (@(posedge clk_in) disable iff (!rst_n_r)
      (match_tick && gate_accumulate_enable && !set_gate && !irq_flag_r)
      |=> !irq_flag_r)
      else $error("match set flag in gated mode");
   run_stop_a: assert property (@(posedge clk_in) disable iff (!rst_n_r)
      (!run_bit && !wr_cnt) |=> $stable(count_register_r))
      else $error("count moved while stopped");
   ps_clear_a: assert property (@(posedge clk_in) disable iff (!rst_n_r)
      ps_clr |=> (ps_cnt_r == 8'h00))
      else $error("prescaler not cleared");
   match_wrap_a: assert property (@(posedge clk_in) disable iff (!rst_n_r)
      (match_tick && !wr_cnt) |=> (count_register_r == 16'h0000))
      else $error("count did not restart");

   // checks on prescaler, bus side and flag sources
   ps_step_a: assert property (@(posedge clk_in) disable iff (!rst_n_r)
      (!ps_clr && !ps_wrap) |=> (ps_cnt_r == $past(ps_cnt_r) + 8'h01))
      else $error("prescaler did not step");
   cnt_load_a: assert property (@(posedge clk_in) disable iff (!rst_n_r)
      (wr_cnt && pstrb_in[1:0] == 2'h3) |=> (count_register_r == $past(pwdata_in[15:0])))
      else $error("count write not taken alone");
   byte_read_a: assert property (@(posedge clk_in) disable iff (!rst_n_r)
      (acc && !pwrite_in && pstrb_in == 4'h1) |-> (prdata_out == 32'h0))
      else $error("byte read returned data");
   zero_per_a: assert property (@(posedge clk_in) disable iff (!rst_n_r)
      (per_zero && !gate_accumulate_enable && !irq_flag_r) |=> !irq_flag_r)
      else $error("zero period set flag");
   match_flag_a: assert property (@(posedge clk_in) disable iff (!rst_n_r)
      (match_tick && !gate_accumulate_enable && !per_zero) |=> irq_flag_r)
      else $error("match did not set flag");
   gate_view_a: assert property (@(posedge clk_in) disable iff (!rst_n_r)
      (acc && !pwrite_in && hit_ctl && clock_source_select) |-> !prdata_out[`BIT_GATE])
      else $error("gate bit read with external source");
   ext_only_a: assert property (@(posedge clk_in) disable iff (!rst_n_r)
      (run_bit && clock_source_select && !ext_tick && !wr_cnt) |=> $stable(count_register_r))
      else $error("count moved without external tick");
   gate_step_a: assert property (@(posedge clk_in) disable iff (!rst_n_r)
      (gate_accumulate_enable && run_bit && pin_sync_r && int_tick && !match && !wr_cnt)
      |=> (count_register_r == $past(count_register_r) + 16'h0001))
      else $error("gated count did not step");
   irq_on_a: assert property (@(posedge clk_in) disable iff (!rst_n_r)
      (irq_flag_r && irq_enable_r && irq_priority_r != 3'h0) |-> irq_out)
      else $error("request missing");
   per_byte_a: assert property (@(posedge clk_in) disable iff (!rst_n_r)
      (wr_per && pstrb_in[1:0] == 2'h1) |=> $stable(period_register_r[15:8]))
      else $error("byte write touched high byte");
   ctl_load_a: assert property (@(posedge clk_in) disable iff (!rst_n_r)
      (wr_ctl && pstrb_in[1:0] == 2'h3) |=> (control_register_r == ($past(pwdata_in[15:0]) & `CTRL_MASK)))
      else $error("control write not taken");
   stop_tick_a: assert property (@(posedge clk_in) disable iff (!rst_n_r)
      !run_bit |-> !tick)
      else $error("tick while stopped");
   gate_idle_a: assert property (@(posedge clk_in) disable iff (!rst_n_r)
      (gate_accumulate_enable && !pin_sync_r) |-> !tick)
      else $error("tick with gate low");
endmodule : gated_prescaled_timer16
`default_nettype wire

// ### gate_pin_model.sv
// far-side model driving the external clock or gate pin
`timescale 1ns/100ps
`default_nettype none
module gate_pin_model
(
   input wire logic clk_in, // bench clock
   input wire logic gate_level_in, // gate level wanted
   input wire logic clock_run_in, // run the pin as a clock
   output logic pin_out // pin level
);
   logic [2:0] phase_r;
   // pin toggles every four clocks inside a clock burst, else follows gate
   always_ff @(posedge clk_in)
   begin
      phase_r <= phase_r + 3'h1;
      pin_out <= clock_run_in ? phase_r[2] : gate_level_in;
   end
   initial phase_r = 3'h0;
   initial pin_out = 1'b0;
endmodule : gate_pin_model
`default_nettype wire

// ### gated_prescaled_timer16_test.sv
// self-checking bench for the gated prescaled timer
`include "timer16_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module gated_prescaled_timer16_test;
   logic clk=0, rst_n=0, psel=0, pen=0, pwr=0, gate=0, crun=0, pin, rdy, err, irq;
   logic [11:0] addr=12'h000;
   logic [31:0] wd=32'h0, rd, got;
   logic [3:0] strb=4'h0;
   timer16_pkg::word_t cnt;
   int n_fail=0, comparisons=0;
   logic [15:0] c1;
   gated_prescaled_timer16 i_gated_prescaled_timer16 (.clk_in(clk),
      .rst_n_in(rst_n), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
      .paddr_in(addr), .pwdata_in(wd), .pstrb_in(strb), .prdata_out(rd),
      .pready_out(rdy), .pslverr_out(err), .ext_clock_gate_pin_in(pin),
      .count_out(cnt), .irq_out(irq));
   gate_pin_model i_gate_pin_model (.clk_in(clk), .gate_level_in(gate),
      .clock_run_in(crun), .pin_out(pin));
   always #2.5 clk = ~clk;
   // compare one value
   task chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e)
      begin
         n_fail++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask : chk
   task complete_run;
      $display("fails %0d comparisons %0d", n_fail, comparisons);
      if (n_fail == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : complete_run
   // one apb transfer, held until pready is seen high
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
            input logic [3:0] s);
      int i;
      @(posedge clk);
      psel <= 1; pen <= 0; pwr <= w; addr <= a; wd <= d; strb <= s;
      @(posedge clk);
      pen <= 1;
      for (i = 0; i < 20; i++)
      begin
         @(posedge clk);
         if (rdy === 1'b1)
            break;
      end
      if (i == 20)
      begin
         chk(0, 1);
         complete_run();
      end
      got = rd;
      psel <= 0; pen <= 0;
   endtask : apb
   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1, a, d, 4'h3);
   endtask : wr
   // wait for the interrupt request under a bound
   task wait_irq(input int n);
      int i;
      for (i = 0; i < n && irq !== 1'b1; i++)
         @(negedge clk);
      chk(irq, 1);
      if (irq !== 1'b1)
         complete_run();
   endtask : wait_irq
   task t_reset;
      apb(0, `OFS_COUNT, 0, 4'h0); chk(got, 0);
      apb(0, `OFS_PERIOD, 0, 4'h0); chk(got, 32'h0000FFFF);
      apb(0, `OFS_CONTROL, 0, 4'h0); chk(got, 0);
      apb(0, 12'h010, 0, 4'h0); chk(err, 1);
      $display("test reset done");
   endtask : t_reset
   task t_bytes;
      wr(`OFS_COUNT, 32'h1234);
      apb(1, `OFS_COUNT, 32'h5600, 4'h2);
      apb(0, `OFS_COUNT, 0, 4'h3); chk(got, 32'h5634);
      apb(0, `OFS_COUNT, 0, 4'h1); chk(got, 0);
      $display("test bytes done");
   endtask : t_bytes
   task t_prescale;
      int k, div, n;
      for (k = 0; k < 4; k++)
      begin
         div = (k == 0) ? 1 : (k == 1) ? 8 : (k == 2) ? 64 : 256;
         wr(`OFS_CONTROL, 0);
         wr(`OFS_COUNT, 0);
         wr(`OFS_CONTROL, 32'h8000 | (k << 4));
         repeat (1024) @(posedge clk);
         apb(0, `OFS_COUNT, 0, 4'h3);
         n = 1024 / div;
         chk(got >= n - 1 && got <= n + 4, 1);
      end
      $display("test prescale done");
   endtask : t_prescale
   task t_match;
      wr(`OFS_CONTROL, 0);
      wr(`OFS_COUNT, 0);
      wr(`OFS_PERIOD, 3);
      wr(`OFS_IRQ, 32'h06);
      wr(`OFS_CONTROL, 32'h8000);
      wait_irq(20);
      chk(cnt <= 3, 1);
      wr(`OFS_CONTROL, 0);
      repeat (10) @(posedge clk);
      chk(irq, 1);
      wr(`OFS_IRQ, 32'h03);
      #1 chk(irq, 0);
      wr(`OFS_IRQ, 32'h02);
      apb(0, `OFS_IRQ, 0, 4'h3); chk(got[0], 0);
      wr(`OFS_PERIOD, 0);
      wr(`OFS_COUNT, 0);
      wr(`OFS_CONTROL, 32'h8000);
      repeat (100) @(posedge clk);
      apb(0, `OFS_IRQ, 0, 4'h3); chk(got[0], 0);
      $display("test match done");
   endtask : t_match
   task t_gate;
      wr(`OFS_CONTROL, 0);
      wr(`OFS_PERIOD, 32'hFFFF);
      wr(`OFS_COUNT, 0);
      wr(`OFS_IRQ, 32'h06);
      wr(`OFS_CONTROL, 32'h8040);
      @(posedge clk) gate <= 1;
      repeat (40) @(posedge clk);
      gate <= 0;
      wait_irq(12);
      repeat (4) @(posedge clk);
      c1 = cnt;
      chk(c1 >= 34 && c1 <= 42, 1);
      repeat (20) @(posedge clk);
      chk(cnt, c1);
      @(posedge clk) gate <= 1;
      repeat (10) @(posedge clk);
      gate <= 0;
      repeat (8) @(posedge clk);
      chk(cnt > c1 && cnt <= c1 + 12, 1);
      wr(`OFS_IRQ, 0);
      $display("test gate done");
   endtask : t_gate
   task t_ext;
      wr(`OFS_CONTROL, 0);
      wr(`OFS_COUNT, 0);
      wr(`OFS_CONTROL, 32'h8002);
      @(posedge clk) crun <= 1;
      repeat (160) @(posedge clk);
      crun <= 0;
      repeat (8) @(posedge clk);
      chk(cnt >= 17 && cnt <= 21, 1);
      $display("test external done");
   endtask : t_ext
   initial
   begin
      repeat (20) @(posedge clk);
      rst_n <= 1;
      repeat (3) @(posedge clk);
      t_reset();
      t_bytes();
      t_prescale();
      t_match();
      t_gate();
      t_ext();
      complete_run();
   end
endmodule : gated_prescaled_timer16_test
`default_nettype wire
